// ==== ocr_output_config_registers.sv ====
/*
  Output configuration register bank of a serial-link video
  deserializer, reached over AHB-Lite as the only slave.
  Assumes a decoded strap level on mode_strap_pin0 (bit 2 mapping
  mode, bits 1:0 output mode) and recovered link data on clk.
*/
// What this block does
// (RULE1) With the floor enabled, equalization starts from the 4-bit floor.
// (RULE2) With port 1 selected, floor writes go to port 1, reads show port 0.
// (RULE3) Mode register bit 7 is read-only and reports the strapped map mode.
// (RULE4) Mode register bit 6 is a writable override of the strapped mode.
// (RULE5) Mode register bit 5 holds the mapping mode used under override.
// (RULE6) The 2-bit output mode picks dual, swapped, single or replicated.
// (RULE7) The output mode loads from the strap at reset and stays writable.
// (RULE8) The 2-bit swing field resets to zero and picks one of four swings.
// (RULE9) Software selects port 1 before changing the port 1 swing.
// (RULE10) Monitor select bit 7 routes input 0 data when 0, input 1 when 1.
// (RULE11) Software sets the monitor enable so the driver sends the data.
// (RULE12) Software keeps the monitor select consistent with its twin field.
// (RULE13) Monitor enable bit 3 turns the driver on, and resets to off.
// (RULE14) Read-only reserved bits read zero; writable ones just store.
`timescale 1ns/1ns
`default_nettype none
module ocr_output_config_registers
  import ocr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  mode_strap_pin0,
  input  wire logic        link_in0,
  input  wire logic        link_in1,
  output logic      [3:0]  eq_floor_start_p0,
  output logic      [3:0]  eq_floor_start_p1,
  output logic      [1:0]  eq_floor_en,
  output logic             map_mode,
  output logic      [1:0]  pixel_port_mode,
  output logic      [1:0]  output_swing_sel_p0,
  output logic      [1:0]  output_swing_sel_p1,
  output logic             monitor_drv_en,
  output logic             monitor_out
);

  // word index match, shared by read and write decode
  function automatic logic hit(input logic [29:0] widx,
                               input logic [7:0]  idx);
    hit = (widx == {22'h0, idx});
  endfunction

  // bus slave state, captured word index and registered answer
  ocr_bus_state_e st_q, st_d;
  logic [29:0] aidx_q, aidx_d;
  logic [31:0] hrdata_d;
  logic        hreadyout_d;
  logic        take;

  // port select and equalizer floor settings; port 1 has its own floor
  logic        port_sel_q, port_sel_d;
  logic [1:0]  floor_en_q, floor_en_d;
  logic [3:0]  floor_p0_q, floor_p0_d;
  logic [3:0]  floor_p1_q, floor_p1_d;
  logic [3:0]  floor_hi_q, floor_hi_d;

  // mapping mode from strap or override, and pixel output mode
  logic        map_strap_q, map_strap_d;
  logic        map_ovr_q, map_ovr_d;
  logic        map_reg_q, map_reg_d;
  logic [1:0]  ppm_q, ppm_d;

  // swing copies per port; reserved bits stored with the code
  logic [7:0]  swing_p0_q, swing_p0_d;
  logic [7:0]  swing_p1_q, swing_p1_d;

  // loop-through monitor routing and driver enable
  logic        mon_sel_q, mon_sel_d;
  logic        mon_en_q, mon_en_d;
  logic        mon_out_d;

  // captured strap level and the low byte of the write data
  logic [2:0]  strap_val;
  logic        strap_load;
  logic [7:0]  wb;

  // strap level synchronised and captured once after reset release;
  // the pin is read nowhere else
  ocr_strap_sampler #(
    .W (3)
  ) u_strap (
    .clk          (clk),
    .rstn         (rstn),
    .strap_pin    (mode_strap_pin0),
    .strap_val_q  (strap_val),
    .strap_load_q (strap_load)
  );

  // a transfer is taken when selected, NONSEQ or SEQ (htrans[1] set) and the bus is ready;
  // only the low byte of a word carries register bits
  assign take = hsel && htrans[1] && hready;
  assign wb   = hwdata[7:0];

  // bus sequencing: writes need no wait, reads take one wait state
  always_comb
  begin
    st_d        = st_q;
    aidx_d      = aidx_q;
    hreadyout_d = 1'b1;
    case (st_q)
      OCR_ST_IDLE, OCR_ST_WRITE, OCR_ST_RDDONE:
      begin
        if (take)
        begin
          aidx_d = haddr[31:2];
          st_d   = hwrite ? OCR_ST_WRITE : OCR_ST_RDWAIT;
        end
        else
          st_d = OCR_ST_IDLE;
      end
      OCR_ST_RDWAIT:
        st_d = OCR_ST_RDDONE;
      default:
        st_d = OCR_ST_IDLE;
    endcase
    if (st_d == OCR_ST_RDWAIT)
      hreadyout_d = 1'b0;
  end

  // read data, built while the read waits so writes have landed
  always_comb
  begin
    hrdata_d = hrdata;
    if (st_q == OCR_ST_RDWAIT)
    begin
      hrdata_d = 32'h0000_0000; // unmapped reads as zero
      if (hit(aidx_q, OCR_IDX_PORT_SEL))
        hrdata_d[OCR_POS_PORT_SEL] = port_sel_q;
      if (hit(aidx_q, OCR_IDX_FLOOR_CTL))
        hrdata_d[OCR_POS_FLOOR_EN +: 2] = floor_en_q;
      if (hit(aidx_q, OCR_IDX_EQ_FLOOR))
        hrdata_d[7:0] = {floor_hi_q, floor_p0_q}; // RULE2
      if (hit(aidx_q, OCR_IDX_TX_MODE))
      begin
        hrdata_d[OCR_POS_MAP_STRAP] = map_strap_q; // RULE3
        hrdata_d[OCR_POS_MAP_OVR]   = map_ovr_q;
        hrdata_d[OCR_POS_MAP_REG]   = map_reg_q;
        hrdata_d[1:0]               = ppm_q; // bits 4:2 read zero RULE14
      end
      if (hit(aidx_q, OCR_IDX_SWING))
        hrdata_d[7:0] = port_sel_q ? swing_p1_q : swing_p0_q;
      if (hit(aidx_q, OCR_IDX_MON_SEL))
        hrdata_d[OCR_POS_MON_SEL] = mon_sel_q; // RULE14
      if (hit(aidx_q, OCR_IDX_MON_EN))
        hrdata_d[OCR_POS_MON_EN] = mon_en_q; // RULE14
    end
  end

  // register writes in the write data phase; strap load first
  always_comb
  begin
    port_sel_d  = port_sel_q;
    floor_en_d  = floor_en_q;
    floor_p0_d  = floor_p0_q;
    floor_p1_d  = floor_p1_q;
    floor_hi_d  = floor_hi_q;
    map_strap_d = map_strap_q;
    map_ovr_d   = map_ovr_q;
    map_reg_d   = map_reg_q;
    ppm_d       = ppm_q;
    swing_p0_d  = swing_p0_q;
    swing_p1_d  = swing_p1_q;
    mon_sel_d   = mon_sel_q;
    mon_en_d    = mon_en_q;
    if (strap_load)
    begin
      map_strap_d = strap_val[2]; // RULE3
      ppm_d       = strap_val[1:0]; // RULE7
    end
    // a mode register write in the same cycle overrides the strapped output mode, not the strapped map mode
    if (st_q == OCR_ST_WRITE)
    begin
      if (hit(aidx_q, OCR_IDX_PORT_SEL))
        port_sel_d = wb[OCR_POS_PORT_SEL];
      if (hit(aidx_q, OCR_IDX_FLOOR_CTL))
        floor_en_d = wb[OCR_POS_FLOOR_EN +: 2];
      // floor writes follow the port select; floor reads never do
      if (hit(aidx_q, OCR_IDX_EQ_FLOOR))
      begin
        floor_hi_d = wb[7:4]; // RULE14
        if (port_sel_q)
          floor_p1_d = wb[3:0]; // RULE2
        else
          floor_p0_d = wb[3:0];
      end
      if (hit(aidx_q, OCR_IDX_TX_MODE))
      begin
        map_ovr_d = wb[OCR_POS_MAP_OVR]; // RULE4
        map_reg_d = wb[OCR_POS_MAP_REG]; // RULE5
        ppm_d     = wb[1:0]; // RULE7
      end
      // the port select steers a swing write to one copy only
      if (hit(aidx_q, OCR_IDX_SWING))
      begin
        if (port_sel_q)
          swing_p1_d = wb; // RULE9
        else
          swing_p0_d = wb; // RULE8
      end
      if (hit(aidx_q, OCR_IDX_MON_SEL))
        mon_sel_d = wb[OCR_POS_MON_SEL]; // RULE10
      if (hit(aidx_q, OCR_IDX_MON_EN))
        mon_en_d = wb[OCR_POS_MON_EN]; // RULE13
    end
  end

  // monitor path: selected recovered data, quiet while disabled
  always_comb
  begin
    mon_out_d = 1'b0;
    if (mon_en_q)
      mon_out_d = mon_sel_q ? link_in1 : link_in0; // RULE10 RULE13
  end

  // bus and register state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q        <= OCR_ST_IDLE;
      aidx_q      <= 30'h0000_0000;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      port_sel_q  <= 1'b0;
      floor_en_q  <= OCR_RST_FLOOR_EN;
      floor_p0_q  <= OCR_RST_EQ_FLOOR[3:0];
      floor_p1_q  <= OCR_RST_EQ_FLOOR[3:0];
      floor_hi_q  <= OCR_RST_EQ_FLOOR[7:4];
      map_strap_q <= 1'b0;
      map_ovr_q   <= 1'b0;
      map_reg_q   <= 1'b0;
      ppm_q       <= OCR_PPM_DUAL;
      swing_p0_q  <= OCR_RST_SWING;
      swing_p1_q  <= OCR_RST_SWING;
      mon_sel_q   <= 1'b0;
      mon_en_q    <= 1'b0;
      monitor_out <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      aidx_q      <= aidx_d;
      hrdata      <= hrdata_d;
      hreadyout   <= hreadyout_d;
      hresp       <= 1'b0; // always OKAY
      port_sel_q  <= port_sel_d;
      floor_en_q  <= floor_en_d;
      floor_p0_q  <= floor_p0_d;
      floor_p1_q  <= floor_p1_d;
      floor_hi_q  <= floor_hi_d;
      map_strap_q <= map_strap_d;
      map_ovr_q   <= map_ovr_d;
      map_reg_q   <= map_reg_d;
      ppm_q       <= ppm_d;
      swing_p0_q  <= swing_p0_d;
      swing_p1_q  <= swing_p1_d;
      mon_sel_q   <= mon_sel_d;
      mon_en_q    <= mon_en_d;
      monitor_out <= mon_out_d;
    end
  end

  // control outputs, one register stage behind the settings
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eq_floor_start_p0   <= OCR_RST_EQ_FLOOR[3:0];
      eq_floor_start_p1   <= OCR_RST_EQ_FLOOR[3:0];
      eq_floor_en         <= OCR_RST_FLOOR_EN;
      map_mode            <= 1'b0;
      pixel_port_mode     <= OCR_PPM_DUAL;
      output_swing_sel_p0 <= 2'h0;
      output_swing_sel_p1 <= 2'h0;
      monitor_drv_en      <= 1'b0;
    end
    else
    begin
      eq_floor_start_p0   <= floor_p0_q; // RULE1
      eq_floor_start_p1   <= floor_p1_q; // RULE1
      eq_floor_en         <= floor_en_q; // RULE1
      map_mode            <= map_ovr_q ? map_reg_q : map_strap_q; // RULE4 RULE5
      pixel_port_mode     <= ppm_q; // RULE6
      output_swing_sel_p0 <= swing_p0_q[1:0]; // RULE8
      output_swing_sel_p1 <= swing_p1_q[1:0]; // RULE8
      monitor_drv_en      <= mon_en_q; // RULE13
    end
  end

endmodule
`default_nettype wire

// ==== ocr_output_config_registers_chk.sv ====
/*
  Checker for the output configuration register bank.
  Assumes it is bound to the bank and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module ocr_output_config_registers_chk
  import ocr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        link_in0,
  input wire logic        link_in1,
  input wire logic [3:0]  eq_floor_start_p0,
  input wire logic [1:0]  eq_floor_en,
  input wire logic        map_mode,
  input wire logic [1:0]  pixel_port_mode,
  input wire logic        monitor_drv_en,
  input wire logic        monitor_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a transfer taken, and a read of one word index
  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_rd(logic [7:0] i);
    s_take and !hwrite && haddr == {22'h0, i, 2'b00};
  endsequence

  a_read_wait: assert property (s_take and !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (s_take and hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_high_zero: assert property (s_take and !hwrite |-> ##2 hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_tx_fields: assert property (s_rd(OCR_IDX_TX_MODE) |-> ##2
    hrdata[4:2] == 3'h0 && pixel_port_mode == hrdata[1:0])
    else $error("mode register fields wrong");
  a_map_select: assert property (s_rd(OCR_IDX_TX_MODE) |-> ##2
    map_mode == (hrdata[6] ? hrdata[5] : hrdata[7]))
    else $error("mapping mode wrong");
  a_floor_read: assert property (s_rd(OCR_IDX_EQ_FLOOR) |-> ##2
    hrdata[3:0] == eq_floor_start_p0)
    else $error("floor readback wrong");
  a_floor_en: assert property (s_rd(OCR_IDX_FLOOR_CTL) |-> ##2
    hrdata[5:4] == eq_floor_en)
    else $error("floor enable wrong");
  a_mon_en_read: assert property (s_rd(OCR_IDX_MON_EN) |-> ##2
    hrdata[7:0] == {4'h0, monitor_drv_en, 3'h0})
    else $error("monitor enable readback wrong");
  a_mon_off: assert property (!monitor_drv_en |-> !monitor_out)
    else $error("monitor drives while off");
  a_mon_data: assert property (monitor_drv_en &&
    $past(link_in0) == $past(link_in1) |-> monitor_out == $past(link_in0))
    else $error("monitor data wrong");
endmodule

bind ocr_output_config_registers ocr_output_config_registers_chk u_chk (
  .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .link_in0, .link_in1, .eq_floor_start_p0,
  .eq_floor_en, .map_mode, .pixel_port_mode, .monitor_drv_en, .monitor_out
);
`default_nettype wire

// ==== ocr_output_config_registers_test.sv ====
/*
  Self-checking bench for the output configuration register bank.
  Assumes one AHB-Lite master and a decoded strap level.
*/
`timescale 1ns/1ns
`default_nettype none
module ocr_output_config_registers_test
  import ocr_pkg::*;
;
  logic        clk, rstn, hsel, hwrite, link_in0, link_in1;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, fl_en, ppm, sw0, sw1;
  logic [2:0]  hsize, strap;
  logic [3:0]  fl0, fl1;
  logic        hreadyout, hresp, map_mode, mon_en, mon_out;
  int          n_mismatch, n_checks;

  ocr_output_config_registers u_ocr_output_config_registers (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_strap_pin0(strap), .link_in0(link_in0), .link_in1(link_in1),
    .eq_floor_start_p0(fl0), .eq_floor_start_p1(fl1), .eq_floor_en(fl_en),
    .map_mode(map_mode), .pixel_port_mode(ppm), .output_swing_sel_p0(sw0),
    .output_swing_sel_p1(sw1), .monitor_drv_en(mon_en),
    .monitor_out(mon_out)
  );

  // clock of 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // one single transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d, output logic [31:0] q);
    haddr  <= {22'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    hsel   <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, i, 32'h0, q);
    chk(q, e);
  endtask

  // let the control pins follow the registers
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // watchdog against a hung bus
  initial
  begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    {rstn, hsel, hwrite, link_in0, link_in1} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    strap = 3'b110;
    n_mismatch = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(OCR_IDX_TX_MODE, 32'h82);
    chk(32'({map_mode, ppm}), 32'h6);
    rd(OCR_IDX_SWING, 32'h0);
    rd(OCR_IDX_MON_EN, 32'h0);
    rd(OCR_IDX_MON_SEL, 32'h0);
    // every output mode code; strap mapping holds without override
    for (int m = 0; m < 4; m++)
    begin
      wr(OCR_IDX_TX_MODE, m);
      settle();
      chk(32'({map_mode, ppm}), 32'h4 | m);
      rd(OCR_IDX_TX_MODE, 32'h80 | m);
    end
    wr(OCR_IDX_TX_MODE, 32'h40);
    settle();
    chk(32'(map_mode), 32'h0);
    wr(OCR_IDX_TX_MODE, 32'h7F);
    rd(OCR_IDX_TX_MODE, 32'hE3);
    // swing per port through the port select
    wr(OCR_IDX_SWING, 32'h03);
    wr(OCR_IDX_PORT_SEL, 32'h1);
    wr(OCR_IDX_SWING, 32'hF2);
    settle();
    chk(32'({sw0, sw1}), 32'hE);
    rd(OCR_IDX_SWING, 32'hF2);
    // floor write lands on port 1, readback shows port 0
    wr(OCR_IDX_EQ_FLOOR, 32'h05);
    rd(OCR_IDX_EQ_FLOOR, 32'h08);
    wr(OCR_IDX_PORT_SEL, 32'h0);
    rd(OCR_IDX_SWING, 32'h03);
    wr(OCR_IDX_EQ_FLOOR, 32'h3A);
    settle();
    chk(32'({fl0, fl1}), 32'hA5);
    wr(OCR_IDX_FLOOR_CTL, 32'h30);
    rd(OCR_IDX_FLOOR_CTL, 32'h30);
    chk(32'(fl_en), 32'h3);
    // monitor routing and enable
    wr(OCR_IDX_MON_SEL, 32'hFF);
    rd(OCR_IDX_MON_SEL, 32'h80);
    wr(OCR_IDX_MON_EN, 32'hFF);
    rd(OCR_IDX_MON_EN, 32'h08);
    link_in1 <= 1'b1;
    settle();
    chk(32'({mon_en, mon_out}), 32'h3);
    wr(OCR_IDX_MON_SEL, 32'h0);
    settle();
    chk(32'(mon_out), 32'h0);
    link_in0 <= 1'b1;
    settle();
    chk(32'(mon_out), 32'h1);
    wr(OCR_IDX_MON_EN, 32'h0);
    settle();
    chk(32'({mon_en, mon_out}), 32'h0);
    // unmapped word ignores writes and reads zero
    wr(8'h40, 32'hFF);
    rd(8'h40, 32'h0);
    // second reset with another strap level
    strap <= 3'b001;
    rstn  <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(OCR_IDX_TX_MODE, 32'h01);
    chk(32'(map_mode), 32'h0);
    // register map bit is ignored without override, used with it
    wr(OCR_IDX_TX_MODE, 32'h21);
    settle();
    chk(32'({map_mode, ppm}), 32'h1);
    wr(OCR_IDX_TX_MODE, 32'h61);
    settle();
    chk(32'({map_mode, ppm}), 32'h5);
    rd(OCR_IDX_SWING, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== ocr_pkg.sv ====
/*
  Shared constants for the output configuration register bank:
  register indices, field positions and values after reset.
  Assumes a 32-bit register bus where each register takes one
  word, so the byte address of a register is four times its index.
*/
package ocr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] OCR_IDX_PORT_SEL   = 8'h34;
  localparam logic [7:0] OCR_IDX_FLOOR_CTL  = 8'h35;
  localparam logic [7:0] OCR_IDX_EQ_FLOOR   = 8'h45;
  localparam logic [7:0] OCR_IDX_TX_MODE    = 8'h49;
  localparam logic [7:0] OCR_IDX_SWING      = 8'h4B;
  localparam logic [7:0] OCR_IDX_MON_SEL    = 8'h52;
  localparam logic [7:0] OCR_IDX_MON_EN     = 8'h56;

  // field positions
  localparam int OCR_POS_PORT_SEL   = 0;
  localparam int OCR_POS_FLOOR_EN   = 4;
  localparam int OCR_POS_MAP_STRAP  = 7;
  localparam int OCR_POS_MAP_OVR    = 6;
  localparam int OCR_POS_MAP_REG    = 5;
  localparam int OCR_POS_MON_SEL    = 7;
  localparam int OCR_POS_MON_EN     = 3;

  // values after reset
  localparam logic [7:0] OCR_RST_EQ_FLOOR = 8'h08;
  localparam logic [7:0] OCR_RST_SWING    = 8'h00;
  localparam logic [1:0] OCR_RST_FLOOR_EN = 2'h0;

  // strap sampler: stages filled before the pin level is trusted
  localparam logic [1:0] OCR_STRAP_FILL = 2'h3;

  // output mode codes
  localparam logic [1:0] OCR_PPM_DUAL      = 2'h0;
  localparam logic [1:0] OCR_PPM_DUAL_SWAP = 2'h1;
  localparam logic [1:0] OCR_PPM_SINGLE    = 2'h2;
  localparam logic [1:0] OCR_PPM_REPLICATE = 2'h3;

  // bus slave states
  typedef enum logic [3:0] {
    OCR_ST_IDLE   = 4'b0001,
    OCR_ST_WRITE  = 4'b0010,
    OCR_ST_RDWAIT = 4'b0100,
    OCR_ST_RDDONE = 4'b1000
  } ocr_bus_state_e;

endpackage

// ==== ocr_strap_sampler.sv ====
/*
  Strap sampler: brings the decoded mode-select strap level into
  the clock domain and captures it once after reset release.
  Assumes the strap pin is stable around reset release.
*/
`timescale 1ns/1ns
`default_nettype none
module ocr_strap_sampler
  import ocr_pkg::*;
#(
  parameter int W = 3
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] strap_pin,
  output logic     [W-1:0]  strap_val_q,
  output logic              strap_load_q
);

  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [1:0]   fill_q, fill_d;
  logic         done_q, done_d;
  logic [W-1:0] strap_val_d;
  logic         strap_load_d;

  // capture once the last two stages agree after the chain filled
  always_comb
  begin
    fill_d       = fill_q;
    done_d       = done_q;
    strap_val_d  = strap_val_q;
    strap_load_d = 1'b0;
    if (fill_q != OCR_STRAP_FILL)
      fill_d = fill_q + 2'h1;
    else if (!done_q && (s2_q == s3_q))
    begin
      done_d       = 1'b1;
      strap_val_d  = s3_q;
      strap_load_d = 1'b1;
    end
  end

  // synchroniser chain and capture state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q         <= '0;
      s2_q         <= '0;
      s3_q         <= '0;
      fill_q       <= 2'h0;
      done_q       <= 1'b0;
      strap_val_q  <= '0;
      strap_load_q <= 1'b0;
    end
    else
    begin
      s1_q         <= strap_pin;
      s2_q         <= s1_q;
      s3_q         <= s2_q;
      fill_q       <= fill_d;
      done_q       <= done_d;
      strap_val_q  <= strap_val_d;
      strap_load_q <= strap_load_d;
    end
  end

endmodule
`default_nettype wire
